// *** desc_decode.sv ***
// Combinational decoder of a transmit descriptor upper quadword.
// Assumes the engine holds upper_qword stable while it reads results.
`timescale 1ns/1ps
`include "tx_cfg.svh"
module desc_decode (
	desc_if.dec d
);
	wire ext = d.upper_qword[`EXT_BIT];
	wire [3:0] descriptor_type_field = d.upper_qword[`TYPE_HI:`TYPE_LO];
	wire [7:0] cmd = d.upper_qword[`CMD_HI:`CMD_LO];
	wire [`LEN_W-1:0] legacy_len = d.upper_qword[`LEN_HI:`LEN_LO];
	wire [19:0] ext_len = d.upper_qword[`DLEN_HI:`LEN_LO];
	wire ext_data = ext && (descriptor_type_field == `TYPE_DATA);
	// extended kinds chosen by type field
	assign d.is_ext = ext;
	assign d.is_ctx = ext && (descriptor_type_field == `TYPE_CTX);
	// legacy and data kinds carry data
	assign d.has_data = !ext || ext_data;
	assign d.buf_len = ext ? ext_len[`LEN_W-1:0] : legacy_len;
	assign d.cso = ext ? 8'h00 : d.upper_qword[`CSO_HI:`CSO_LO];
	assign d.css = ext ? 8'h00 : d.upper_qword[`CSS_HI:`CSS_LO];
	assign d.last_buffer_flag = cmd[`CMD_LAST];
	assign d.insert_checksum_flag = cmd[`CMD_CSUM];
endmodule

// *** desc_if.sv ***
// Decoded descriptor fields between decoder and engine.
// Carries one descriptor's upper quadword and its decoded view.
`timescale 1ns/1ps
`include "tx_cfg.svh"
interface desc_if;
	logic [63:0] upper_qword;
	logic is_ext;
	logic is_ctx;
	logic has_data;
	logic [`LEN_W-1:0] buf_len;
	logic [7:0] cso;
	logic [7:0] css;
	logic last_buffer_flag;
	logic insert_checksum_flag;
	modport dec (input upper_qword, output is_ext, is_ctx, has_data, buf_len, cso, css,
		last_buffer_flag, insert_checksum_flag);
	modport eng (output upper_qword, input is_ext, is_ctx, has_data, buf_len, cso, css,
		last_buffer_flag, insert_checksum_flag);
endinterface

// *** host_mem.sv ***
// Host memory model: 2 KB of qwords, one read outstanding.
// Slow mode halves handshake rate and delays read data.
`timescale 1ns/1ps
module host_mem (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic rd_req,
	input wire logic [63:0] rd_addr,
	output logic rd_ready,
	output logic rd_rvalid,
	output logic [63:0] rd_rdata,
	input wire logic wb_req,
	input wire logic [63:0] wb_addr,
	input wire logic [63:0] wb_data,
	output logic wb_ready
);
	logic [63:0] mem [0:255];
	logic [63:0] addr_reg;
	logic [1:0] dly_reg;
	logic pend_reg;
	logic ph_reg;
	assign rd_ready = rd_req && !pend_reg && !(slow && ph_reg);
	assign wb_ready = wb_req && !(slow && ph_reg);
	always @(posedge clk or negedge reset_n)
		if (!reset_n) begin
			pend_reg <= 1'b0;
			rd_rvalid <= 1'b0;
			ph_reg <= 1'b0;
			rd_rdata <= '0;
		end else begin
			ph_reg <= !ph_reg;
			rd_rvalid <= 1'b0;
			// Idle data lines keep changing
			rd_rdata <= ~rd_rdata;
			if (wb_ready)
				mem[wb_addr[10:3]] <= wb_data;
			if (rd_ready) begin
				pend_reg <= 1'b1;
				addr_reg <= rd_addr;
				dly_reg <= slow ? 2'h3 : 2'h0;
			end else if (pend_reg && dly_reg != 2'h0)
				dly_reg <= dly_reg - 2'h1;
			else if (pend_reg) begin
				pend_reg <= 1'b0;
				rd_rvalid <= 1'b1;
				rd_rdata <= mem[addr_reg[10:3]];
			end
		end
endmodule

// *** tb.sv ***
// Testbench for the transmit descriptor engine.
// Ring of four descriptors at 0, buffers from 0x400 in host_mem.
`timescale 1ns/1ps
module tb;
	logic clk, reset_n, enable, slow, link_up, tx_ready;
	logic [63:0] ring_base, rd_addr, rd_rdata, wb_addr, wb_data, ctx_lower, ctx_upper;
	logic [15:0] ring_size, tail_ptr, head_ptr;
	logic rd_req, rd_ready, rd_rvalid, wb_req, wb_ready, done_irq, ctx_load, pkt_commit;
	logic pkt_csum_insert, len_error, tx_valid, tx_last;
	logic [7:0] pkt_cso, pkt_css, tx_data;
	logic [7:0] rx_q[$];
	int error_cnt, checks_done, irq_cnt, commit_cnt, ctx_cnt;
	tx_descriptor_fetch u_tx_descriptor_fetch (.clk, .reset_n, .enable, .ring_base, .ring_size,
		.tail_ptr, .head_ptr, .rd_req, .rd_addr, .rd_ready, .rd_rvalid, .rd_rdata, .wb_req,
		.wb_addr, .wb_data, .wb_ready, .done_irq, .ctx_lower, .ctx_upper, .ctx_load, .pkt_commit,
		.pkt_csum_insert, .pkt_cso, .pkt_css, .len_error, .link_up, .tx_valid, .tx_ready,
		.tx_data, .tx_last);
	host_mem u_host_mem (.clk, .reset_n, .slow, .rd_req, .rd_addr, .rd_ready, .rd_rvalid,
		.rd_rdata, .wb_req, .wb_addr, .wb_data, .wb_ready);
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			rx_q.push_back(tx_data);
		irq_cnt += done_irq;
		commit_cnt += pkt_commit;
		ctx_cnt += ctx_load;
	end
	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic put_buf(input logic [63:0] a, input int n);
		for (int i = 0; i < n; i++)
			u_host_mem.mem[(a + i) >> 3][((a + i) & 7) * 8 +: 8] = 8'(a + i) ^ 8'h5a;
	endtask
	task automatic put_desc(input int idx, input logic [63:0] lo, input logic [63:0] up);
		u_host_mem.mem[idx * 2] = lo;
		u_host_mem.mem[idx * 2 + 1] = up;
	endtask
	task automatic check_rx(input logic [63:0] a, input int n);
		for (int i = 0; i < n; i++)
			check("tx byte", 8'(a + i) ^ 8'h5a, rx_q.size() ? rx_q.pop_front() : 8'hxx);
		check("leftover", 0, rx_q.size());
	endtask
	function automatic logic [63:0] wb_exp(input logic [63:0] up);
		return {up[63:40], 4'h0, up[35:32] | 4'h1, up[31:0]};
	endfunction
	task automatic run(input logic [15:0] t);
		int quiet;
		quiet = 0;
		irq_cnt = 0;
		commit_cnt = 0;
		tail_ptr = t;
		for (int n = 0; n < 4000 && quiet < 4; n++) begin
			@(posedge clk);
			#1;
			quiet = (head_ptr === tail_ptr && tx_valid === 1'b0 && wb_req === 1'b0) ? quiet + 1 : 0;
		end
		check("idle", 1, quiet >= 4);
	endtask
	task automatic t_legacy;
		put_buf(64'h0000_0000_0000_0401, 13);
		put_desc(0, 64'h0000_0000_0000_0401, 64'h1234_0200_0504_000d);
		run(16'h0001);
		check_rx(64'h0000_0000_0000_0401, 13);
		check("irq", 1, irq_cnt);
		check("commit", 1, commit_cnt);
		check("csum", 1, pkt_csum_insert);
		check("cso", 4, pkt_cso);
		check("css", 2, pkt_css);
		check("wb", wb_exp(64'h1234_0200_0504_000d), u_host_mem.mem[1]);
		$display("test legacy done");
	endtask
	task automatic t_multi;
		slow = 1'b1;
		put_buf(64'h0000_0000_0000_0440, 12);
		put_desc(1, 64'h0000_0000_0000_0440, 64'h0000_0000_0403_0005);
		put_desc(2, 64'h0000_0000_0000_0445, 64'h0000_0000_0100_0007);
		run(16'h0003);
		check_rx(64'h0000_0000_0000_0440, 12);
		check("irq", 1, irq_cnt);
		check("csum", 0, pkt_csum_insert);
		slow = 1'b0;
		$display("test multi done");
	endtask
	task automatic t_ext;
		ctx_cnt = 0;
		put_buf(64'h0000_0000_0000_04a0, 6);
		put_desc(3, 64'h1111_2222_3333_4444, 64'h5555_6666_2000_0000);
		put_desc(0, 64'h0000_0000_0000_04a0, 64'h0000_0000_2110_0006);
		run(16'h0001);
		check("ctx", 1, ctx_cnt);
		check("ctx lo", 64'h1111_2222_3333_4444, ctx_lower);
		check("ctx up", 64'h5555_6666_2000_0000, ctx_upper);
		check_rx(64'h0000_0000_0000_04a0, 6);
		check("commit", 1, commit_cnt);
		check("wb", wb_exp(64'h0000_0000_2110_0006), u_host_mem.mem[1]);
		$display("test extended done");
	endtask
	task automatic t_link;
		put_buf(64'h0000_0000_0000_0500, 40);
		put_desc(1, 64'h0000_0000_0000_0500, 64'h0000_0000_0100_0028);
		tail_ptr = 16'h0002;
		for (int n = 0; n < 2000 && rx_q.size() < 4; n++)
			@(posedge clk);
		#1;
		link_up = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		rx_q.delete();
		link_up = 1'b1;
		run(16'h0002);
		check_rx(64'h0000_0000_0000_0500, 40);
		$display("test link done");
	endtask
	task automatic t_len;
		put_desc(2, 64'h0000_0000_0000_0600, 64'h0000_0000_0100_ffff);
		tail_ptr = 16'h0003;
		repeat (40) @(posedge clk);
		#1;
		check("len_error", 1, len_error);
		reset_n = 1'b0;
		tail_ptr = '0;
		repeat (2) @(posedge clk);
		check("head", 0, head_ptr);
		check("len_error", 0, len_error);
		#1;
		reset_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("rd_req", 0, rd_req);
		check("sent", 0, rx_q.size());
		$display("test length done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		enable = 1'b1;
		slow = 1'b0;
		link_up = 1'b1;
		tx_ready = 1'b1;
		ring_base = '0;
		ring_size = 16'h0004;
		tail_ptr = '0;
		repeat (12) @(posedge clk);
		check("head", 0, head_ptr);
		check("rd_req", 0, rd_req);
		#1;
		reset_n = 1'b1;
		t_legacy();
		t_multi();
		t_ext();
		t_link();
		t_len();
		t_legacy();
		results();
	end
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		results();
	end
endmodule

// *** tx_cfg.svh ***
// Constants of the transmit descriptor engine.
// Included by the interface and design modules of this block only.
`ifndef TX_CFG_SVH
`define TX_CFG_SVH
`define ADDR_W 64
`define LEN_W 16
`define DESC_BYTES 64'h0000_0000_0000_0010
`define QWORD_BYTES 64'h0000_0000_0000_0008
`define MAX_BUF_LEN 16'h3FA0
`define EXT_BIT 29
`define TYPE_HI 23
`define TYPE_LO 20
`define TYPE_CTX 4'h0
`define TYPE_DATA 4'h1
`define LEN_HI 15
`define LEN_LO 0
`define DLEN_HI 19
`define CSO_HI 23
`define CSO_LO 16
`define CMD_HI 31
`define CMD_LO 24
`define WBSTAT_HI 35
`define WBSTAT_LO 32
`define RSV_HI 39
`define RSV_LO 36
`define CSS_HI 47
`define CSS_LO 40
`define SPC_HI 63
`define SPC_LO 48
`define CMD_LAST 0
`define CMD_CSUM 2
`define WBSTAT_DONE 4'h1
`define FIFO_AW 11
`endif

// *** tx_descriptor_fetch.sv ***
// Transmit descriptor engine: walks the ring, fetches buffers, writes back.
// Memory ports: one outstanding read, 64-bit data, write-back handshake.
`timescale 1ns/1ps
`include "tx_cfg.svh"
// Notes on behaviour
// - Packet data is fetched from host buffers by DMA reads.
// - Transmission starts only once whole packet sits in the FIFO.
// - Completion of a frame's DMA raises an interrupt pulse.
// - Buffers may start at any byte, up to 16288 bytes each.
// - Legacy, extended data and extended context descriptors are supported.
// - Extended flag set means the type field selects interpretation.
// - Extended flag clear means legacy layout.
// - Context descriptors load control registers and fetch no data.
// - Packet interrupted by link loss is sent again after link returns.
// - Write-back quadword holds length, cso, cmd, status, css, special.
// - Checksum insert and offset ignored unless last buffer flag set.
module tx_descriptor_fetch
	import tx_pkg::*;
#(
	parameter int RING_W = 16,
	parameter int FIFO_AW = `FIFO_AW
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [`ADDR_W-1:0] ring_base,
	input wire logic [RING_W-1:0] ring_size,
	input wire logic [RING_W-1:0] tail_ptr,
	output logic [RING_W-1:0] head_ptr,
	output logic rd_req,
	output logic [`ADDR_W-1:0] rd_addr,
	input wire logic rd_ready,
	input wire logic rd_rvalid,
	input wire logic [63:0] rd_rdata,
	output logic wb_req,
	output logic [`ADDR_W-1:0] wb_addr,
	output logic [63:0] wb_data,
	input wire logic wb_ready,
	output logic done_irq,
	output logic [63:0] ctx_lower,
	output logic [63:0] ctx_upper,
	output logic ctx_load,
	output logic pkt_commit,
	output logic pkt_csum_insert,
	output logic [7:0] pkt_cso,
	output logic [7:0] pkt_css,
	output logic len_error,
	input wire logic link_up,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_last
);
	eng_state_t state_reg, state_next;
	logic [RING_W-1:0] head_reg;
	logic [63:0] addr_qword_reg, upper_reg;
	logic [`ADDR_W-1:0] buf_addr_reg;
	logic [`LEN_W-1:0] remain_reg;
	logic [`LEN_W-1:0] pkt_len_reg;
	logic [7:0] css_reg;
	logic waiting_reg;
	logic [7:0] byte_reg;
	logic byte_valid_reg;
	logic byte_last_reg;
	logic commit_reg;
	logic irq_reg;
	logic ctx_load_reg;
	logic [63:0] ctx_lower_reg, ctx_upper_reg;
	logic csum_insert_reg;
	logic [7:0] cso_reg, pkt_css_reg;
	logic len_error_reg;
	logic fifo_ready;

	desc_if dif ();
	desc_decode u_decode (
		.d(dif)
	);
	assign dif.upper_qword = upper_reg;

	tx_fifo #(.AW(FIFO_AW)) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.wr_valid(byte_valid_reg),
		.wr_data(byte_reg),
		.wr_last(byte_last_reg),
		.wr_ready(fifo_ready),
		.commit(commit_reg),
		.link_up(link_up),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.tx_data(tx_data),
		.tx_last(tx_last)
	);

	function automatic logic [RING_W-1:0] ring_next(input logic [RING_W-1:0] idx,
		input logic [RING_W-1:0] size);
		ring_next = (idx + 1'b1 >= size) ? '0 : idx + 1'b1;
	endfunction

	function automatic logic [`LEN_W-1:0] clip_len(input logic [`LEN_W-1:0] len);
		clip_len = (len > `MAX_BUF_LEN) ? `MAX_BUF_LEN : len;
	endfunction

	// ring walk until head meets tail
	wire ring_has_work = enable && (head_reg != tail_ptr);
	// Descriptors sit back to back from the ring base
	wire [`ADDR_W-1:0] desc_addr = ring_base + `ADDR_W'(head_reg) * `DESC_BYTES;
	wire rd_take = rd_req && rd_ready;
	wire wb_take = wb_req && wb_ready;
	wire is_last_buf = dif.last_buffer_flag;
	wire len_too_long = dif.buf_len > `MAX_BUF_LEN;
	// Offsets count from packet start, this buffer included
	wire [`LEN_W-1:0] pkt_total = pkt_len_reg + clip_len(dif.buf_len);
	// Start offset comes from the first buffer of a packet
	wire [7:0] first_css = (pkt_len_reg == '0) ? dif.css : css_reg;
	// checksum only on last buffer, and in range
	wire csum_ok = dif.insert_checksum_flag && is_last_buf && !dif.is_ext
		&& ({8'h00, first_css} < pkt_total) && ({8'h00, dif.cso} < pkt_total);
	wire [5:0] byte_shift = {buf_addr_reg[2:0], 3'h0};
	wire [63:0] shifted = rd_rdata >> byte_shift;
	wire last_byte = (remain_reg == `LEN_W'(1));
	wire [63:0] wb_word = {upper_reg[`SPC_HI:`SPC_LO], upper_reg[`CSS_HI:`CSS_LO], 4'h0,
		upper_reg[`WBSTAT_HI:`WBSTAT_LO] | `WBSTAT_DONE, upper_reg[`CMD_HI:`CMD_LO],
		upper_reg[`CSO_HI:`CSO_LO], upper_reg[`LEN_HI:`LEN_LO]};

	assign head_ptr = head_reg;
	// One read in flight; a held byte blocks the next read
	assign rd_req = !waiting_reg && !byte_valid_reg
		&& ((state_reg == ST_FETCH0) || (state_reg == ST_FETCH1)
		|| ((state_reg == ST_DATA) && fifo_ready && (remain_reg != '0)));
	assign rd_addr = (state_reg == ST_FETCH0) ? desc_addr
		: (state_reg == ST_FETCH1) ? desc_addr + `QWORD_BYTES
		: {buf_addr_reg[`ADDR_W-1:3], 3'h0};
	assign wb_req = (state_reg == ST_WB);
	assign wb_addr = desc_addr + `QWORD_BYTES;
	assign wb_data = wb_word;
	assign done_irq = irq_reg;
	assign ctx_lower = ctx_lower_reg;
	assign ctx_upper = ctx_upper_reg;
	assign ctx_load = ctx_load_reg;
	assign pkt_commit = commit_reg;
	assign pkt_csum_insert = csum_insert_reg;
	assign pkt_cso = cso_reg;
	assign pkt_css = pkt_css_reg;
	assign len_error = len_error_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (ring_has_work) begin
					state_next = ST_FETCH0;
				end
			end
			ST_FETCH0: begin
				if (rd_rvalid) begin
					state_next = ST_FETCH1;
				end
			end
			ST_FETCH1: begin
				if (rd_rvalid) begin
					state_next = ST_DECODE;
				end
			end
			ST_DECODE: begin
				state_next = dif.has_data ? ST_DATA : ST_WB;
			end
			ST_DATA: begin
				// Leave only once the last byte has entered the FIFO
				if (remain_reg == '0 && !waiting_reg && !byte_valid_reg) begin
					state_next = ST_WB;
				end
			end
			ST_WB: begin
				if (wb_take) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			head_reg <= '0;
			waiting_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (rd_take) begin
				waiting_reg <= 1'b1;
			end else if (rd_rvalid) begin
				waiting_reg <= 1'b0;
			end
			// Head steps only after write-back is accepted
			if (state_reg == ST_DONE) begin
				head_reg <= ring_next(head_reg, ring_size);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_qword_reg <= '0;
			upper_reg <= '0;
			buf_addr_reg <= '0;
			remain_reg <= '0;
			css_reg <= '0;
			len_error_reg <= 1'b0;
		end else begin
			if (state_reg == ST_FETCH0 && rd_rvalid) begin
				addr_qword_reg <= rd_rdata;
			end
			if (state_reg == ST_FETCH1 && rd_rvalid) begin
				upper_reg <= rd_rdata;
			end
			if (state_reg == ST_DECODE && dif.has_data) begin
				buf_addr_reg <= addr_qword_reg;
				// lengths above the maximum are clipped and flagged
				remain_reg <= clip_len(dif.buf_len);
				len_error_reg <= len_too_long;
				if (pkt_len_reg == '0) begin
					css_reg <= dif.css;
				end
			end else if (state_reg == ST_DATA && rd_rvalid) begin
				// Any byte alignment: one byte per returned qword
				buf_addr_reg <= buf_addr_reg + 1'b1;
				remain_reg <= remain_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			byte_reg <= '0;
			byte_valid_reg <= 1'b0;
			byte_last_reg <= 1'b0;
		end else begin
			// Byte held until the FIFO takes it
			if (state_reg == ST_DATA && rd_rvalid) begin
				byte_reg <= shifted[7:0];
				byte_valid_reg <= 1'b1;
				byte_last_reg <= last_byte && is_last_buf;
			end else if (fifo_ready) begin
				byte_valid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pkt_len_reg <= '0;
			commit_reg <= 1'b0;
			irq_reg <= 1'b0;
			csum_insert_reg <= 1'b0;
			cso_reg <= '0;
			pkt_css_reg <= '0;
		end else begin
			commit_reg <= 1'b0;
			irq_reg <= 1'b0;
			if (state_reg == ST_DECODE && dif.has_data && is_last_buf) begin
				csum_insert_reg <= csum_ok;
				cso_reg <= csum_ok ? dif.cso : 8'h00;
				pkt_css_reg <= first_css;
			end
			if (state_reg == ST_WB && wb_take && dif.has_data) begin
				pkt_len_reg <= is_last_buf ? '0 : pkt_len_reg + upper_reg[`LEN_HI:`LEN_LO];
				// packet handed to the sender only when complete
				commit_reg <= is_last_buf;
				irq_reg <= is_last_buf;
			end
		end
	end

	// context values kept for later packets
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctx_lower_reg <= '0;
			ctx_upper_reg <= '0;
			ctx_load_reg <= 1'b0;
		end else begin
			ctx_load_reg <= 1'b0;
			if (state_reg == ST_DECODE && dif.is_ctx) begin
				ctx_lower_reg <= addr_qword_reg;
				ctx_upper_reg <= upper_reg;
				ctx_load_reg <= 1'b1;
			end
		end
	end
endmodule

// *** tx_descriptor_fetch_assertions.sv ***
// Port-level assertions for the transmit descriptor engine.
// Bound into every tx_descriptor_fetch; one clock domain.
`timescale 1ns/1ps
module tx_descriptor_fetch_assertions #(
	parameter int RING_W = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [63:0] ring_base,
	input wire logic [RING_W-1:0] ring_size,
	input wire logic [RING_W-1:0] tail_ptr,
	input wire logic [RING_W-1:0] head_ptr,
	input wire logic rd_req,
	input wire logic [63:0] rd_addr,
	input wire logic rd_ready,
	input wire logic wb_req,
	input wire logic [63:0] wb_addr,
	input wire logic [63:0] wb_data,
	input wire logic wb_ready,
	input wire logic done_irq,
	input wire logic ctx_load,
	input wire logic pkt_commit,
	input wire logic link_up,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_last
);
	logic [7:0] pend_reg;
	logic wb_take;
	assign wb_take = wb_req && wb_ready;
	// Committed packets not yet fully sent
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			pend_reg <= 8'h00;
		else
			pend_reg <= pend_reg + 8'(pkt_commit) - 8'(tx_valid && tx_ready && tx_last);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_rd_hold; rd_req && !rd_ready |=> rd_req && $stable(rd_addr); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read request moved");
	property p_head_step; !$stable(head_ptr) |-> head_ptr == $past(head_ptr) + 1'b1
		|| (head_ptr == '0 && $past(head_ptr) + 1'b1 == ring_size); endproperty
	a_head_step: assert property (p_head_step) else $error("head out of order");
	property p_idle; head_ptr == tail_ptr |-> !rd_req; endproperty
	a_idle: assert property (p_idle) else $error("fetch past tail");
	property p_wb_addr; wb_req |-> wb_addr == ring_base + {head_ptr, 4'h0} + 64'h0000_0000_0000_0008;
	endproperty
	a_wb_addr: assert property (p_wb_addr) else $error("write-back address wrong");
	property p_wb_fmt; wb_req |-> wb_data[39:36] == 4'h0 && wb_data[32]; endproperty
	a_wb_fmt: assert property (p_wb_fmt) else $error("write-back status wrong");
	property p_wb_hold; wb_req && !wb_ready |=> wb_req && $stable(wb_data) && $stable(wb_addr);
	endproperty
	a_wb_hold: assert property (p_wb_hold) else $error("write-back moved");
	property p_irq; done_irq |-> $past(wb_take) || $past(wb_take, 2); endproperty
	a_irq: assert property (p_irq) else $error("interrupt without write-back");
	property p_ctx; ctx_load |-> !pkt_commit && !done_irq; endproperty
	a_ctx: assert property (p_ctx) else $error("context load with packet");
	property p_send; tx_valid |-> pend_reg != 8'h00 || pkt_commit; endproperty
	a_send: assert property (p_send) else $error("send before commit");
	property p_link; tx_valid |-> $past(link_up, 2); endproperty
	a_link: assert property (p_link) else $error("send with link down");
	cover property (ctx_load);
	cover property (done_irq);
	cover property (tx_valid && tx_ready && tx_last);
endmodule
bind tx_descriptor_fetch tx_descriptor_fetch_assertions #(.RING_W(RING_W)) u_chk (.clk, .reset_n,
	.ring_base, .ring_size, .tail_ptr, .head_ptr, .rd_req, .rd_addr, .rd_ready, .wb_req,
	.wb_addr, .wb_data, .wb_ready, .done_irq, .ctx_load, .pkt_commit, .link_up, .tx_valid,
	.tx_ready, .tx_last);

// *** tx_fifo.sv ***
// Packet FIFO: bytes become visible only when their packet is committed.
// link_up comes from a pin and is synchronised here.
`timescale 1ns/1ps
`include "tx_cfg.svh"
module tx_fifo #(
	parameter int AW = `FIFO_AW
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic wr_last,
	output logic wr_ready,
	input wire logic commit,
	input wire logic link_up,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_last
);
	logic [8:0] mem [0:(1<<AW)-1];
	logic [AW:0] wr_ptr_reg, commit_ptr_reg, rd_ptr_reg, start_ptr_reg;
	logic link_meta_reg, link_reg;
	logic [8:0] rd_word;
	wire [AW:0] used = wr_ptr_reg - start_ptr_reg;
	wire rd_take = tx_valid && tx_ready;
	// rewind to packet start on link loss
	wire rewind = !link_reg && (rd_ptr_reg != start_ptr_reg);
	assign wr_ready = used != (AW+1)'(1 << AW);
	assign rd_word = mem[rd_ptr_reg[AW-1:0]];
	assign tx_valid = link_reg && (rd_ptr_reg != commit_ptr_reg);
	assign tx_data = rd_word[7:0];
	assign tx_last = rd_word[8];
	always_ff @(posedge clk) begin
		if (wr_valid && wr_ready) begin
			mem[wr_ptr_reg[AW-1:0]] <= {wr_last, wr_data};
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link_meta_reg <= 1'b0;
			link_reg <= 1'b0;
			wr_ptr_reg <= '0;
			commit_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			start_ptr_reg <= '0;
		end else begin
			link_meta_reg <= link_up;
			link_reg <= link_meta_reg;
			if (wr_valid && wr_ready) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (commit) begin
				commit_ptr_reg <= wr_ptr_reg + (AW+1)'(wr_valid && wr_ready);
			end
			if (rewind) begin
				rd_ptr_reg <= start_ptr_reg;
			end else if (rd_take) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				if (tx_last) begin
					start_ptr_reg <= rd_ptr_reg + 1'b1;
				end
			end
		end
	end
endmodule

// *** tx_pkg.sv ***
// Types shared by the transmit descriptor engine modules.
// Uses no macros from tx_cfg.svh.
package tx_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_FETCH0 = 3'h1,
		ST_FETCH1 = 3'h3,
		ST_DECODE = 3'h2,
		ST_DATA = 3'h6,
		ST_WB = 3'h7,
		ST_DONE = 3'h5
	} eng_state_t;
endpackage
